//--- verilog/gpio_cfg_pkg.sv
package gpio_cfg_pkg;

    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W    = 12;

    // word-aligned byte offsets of the register map
    localparam logic [11:0] PIN_DIRECTION_OFFSET          = 12'h000;
    localparam logic [11:0] PULL_RESISTOR_ENABLE_OFFSET   = 12'h004;
    localparam logic [11:0] FUNCTION_SELECT_LOW_OFFSET    = 12'h008;
    localparam logic [11:0] FUNCTION_SELECT_HIGH_OFFSET   = 12'h00C;
    localparam logic [11:0] FUNCTION_SELECT_TOGGLE_OFFSET = 12'h010;
    localparam logic [11:0] IRQ_EDGE_SELECT_OFFSET        = 12'h014;
    localparam logic [11:0] IRQ_ENABLE_OFFSET             = 12'h018;
    localparam logic [11:0] IRQ_FLAGS_OFFSET              = 12'h01C;
    localparam logic [11:0] PIN_OUTPUT_VALUE_OFFSET       = 12'h020;
    localparam logic [11:0] EVENT_STATUS_OFFSET           = 12'h024;
    localparam logic [11:0] EVENT_CLEAR_OFFSET            = 12'h028;
    localparam logic [11:0] EVENT_ENABLE_OFFSET           = 12'h02C;

    localparam logic [7:0] PIN_DIRECTION_RESET        = 8'h00;
    localparam logic [7:0] PULL_RESISTOR_ENABLE_RESET = 8'h00;
    localparam logic [7:0] FUNCTION_SELECT_RESET      = 8'h00;
    localparam logic [7:0] IRQ_EDGE_SELECT_RESET      = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET           = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RESET            = 8'h00;
    localparam logic [7:0] PIN_OUTPUT_VALUE_RESET     = 8'h00;
    localparam logic [2:0] EVENT_RESET                = 3'h0;

    // event status bit positions
    localparam int unsigned EVT_EDGE_BIT    = 0;
    localparam int unsigned EVT_OVERRUN_BIT = 1;
    localparam int unsigned EVT_TOGGLE_BIT  = 2;

    // two-bit function code per pin
    localparam logic [1:0] FUNC_GPIO      = 2'h0;
    localparam logic [1:0] FUNC_PRIMARY   = 2'h1;
    localparam logic [1:0] FUNC_SECONDARY = 2'h2;
    localparam logic [1:0] FUNC_TERTIARY  = 2'h3;

    typedef struct packed {
        logic [7:0] out_value;
        logic [7:0] out_enable;
        logic [7:0] pull_enable;
        logic [7:0] pull_up;
    } pad_ctrl_type;

    typedef struct packed {
        logic [7:0] tertiary;
        logic [7:0] secondary;
        logic [7:0] primary;
    } periph_drive_type;

endpackage : gpio_cfg_pkg

//--- verilog/sync_bank.sv
`timescale 1ns/1ps
// two-stage synchroniser; the first stage feeds only the second
module sync_bank #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sync_bank

//--- verilog/gpio_port_config_regs.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module gpio_port_config_regs (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [7:0]                     pin_in,
    input  wire gpio_cfg_pkg::periph_drive_type periph_drive,
    output gpio_cfg_pkg::pad_ctrl_type          pad_ctrl,
    output logic      [7:0]                     pin_level,
    output logic      [15:0]                    func_code,
    output logic                                irq
);

    logic [7:0]  dir_reg;
    logic [7:0]  ren_reg;
    logic [7:0]  sel_low_reg;
    logic [7:0]  sel_high_reg;
    logic [7:0]  ies_reg;
    logic [7:0]  ie_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  out_reg;
    logic [2:0]  evt_status_reg;
    logic [2:0]  evt_enable_reg;
    logic [7:0]  prev_reg;
    logic [1:0]  warm_reg;
    logic [7:0]  armed;
    logic [7:0]  sync_level;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  edge_hit;
    logic [2:0]  evt_set;
    logic        wr_access;
    logic        setup;
    logic [31:0] rd_value;
    logic        rd_mapped;
    logic [7:0]  wdata;
    logic [7:0]  out_mux;

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign wdata     = pwdata[7:0];

    sync_bank #(.WIDTH(8)) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (sync_level)
    );

    // sync stages and prev_reg leave reset low, so a pin already high would
    // look like a rising edge; edges count only once the pipe has filled
    assign armed    = {8{&warm_reg}};
    assign rise     = sync_level & ~prev_reg & armed;
    assign fall     = ~sync_level & prev_reg & armed;
    assign edge_hit = (rise & ~ies_reg) | (fall & ies_reg);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_reg <= 8'h00;
            warm_reg <= 2'h0;
        end
        else
        begin
            prev_reg <= sync_level;
            if (!(&warm_reg))
                warm_reg <= warm_reg + 2'h1;
        end
    end

    // plain read/write configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_reg <= gpio_cfg_pkg::PIN_DIRECTION_RESET;
            ren_reg <= gpio_cfg_pkg::PULL_RESISTOR_ENABLE_RESET;
            ies_reg <= gpio_cfg_pkg::IRQ_EDGE_SELECT_RESET;
            ie_reg  <= gpio_cfg_pkg::IRQ_ENABLE_RESET;
            out_reg <= gpio_cfg_pkg::PIN_OUTPUT_VALUE_RESET;
            evt_enable_reg <= gpio_cfg_pkg::EVENT_RESET;
        end
        else if (wr_access)
        begin
            unique case (paddr)
                gpio_cfg_pkg::PIN_DIRECTION_OFFSET:        dir_reg <= wdata;
                gpio_cfg_pkg::PULL_RESISTOR_ENABLE_OFFSET: ren_reg <= wdata;
                gpio_cfg_pkg::IRQ_EDGE_SELECT_OFFSET:      ies_reg <= wdata;
                gpio_cfg_pkg::IRQ_ENABLE_OFFSET:           ie_reg  <= wdata;
                gpio_cfg_pkg::PIN_OUTPUT_VALUE_OFFSET:     out_reg <= wdata;
                gpio_cfg_pkg::EVENT_ENABLE_OFFSET:  evt_enable_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // select registers; the toggle write flips both halves in one edge so
    // software never sees a transient function code in between
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_low_reg  <= gpio_cfg_pkg::FUNCTION_SELECT_RESET;
            sel_high_reg <= gpio_cfg_pkg::FUNCTION_SELECT_RESET;
        end
        else if (wr_access)
        begin
            if (paddr == gpio_cfg_pkg::FUNCTION_SELECT_LOW_OFFSET)
                sel_low_reg <= wdata;
            if (paddr == gpio_cfg_pkg::FUNCTION_SELECT_HIGH_OFFSET)
                sel_high_reg <= wdata;
            if (paddr == gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET)
            begin
                sel_low_reg  <= sel_low_reg ^ wdata;
                sel_high_reg <= sel_high_reg ^ wdata;
            end
        end
    end

    // pin flags: an edge in the same cycle as a software write wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= gpio_cfg_pkg::IRQ_FLAGS_RESET;
        else if (wr_access && paddr == gpio_cfg_pkg::IRQ_FLAGS_OFFSET)
            flags_reg <= wdata | edge_hit;
        else
            flags_reg <= flags_reg | edge_hit;
    end

    assign evt_set[gpio_cfg_pkg::EVT_EDGE_BIT]    = |edge_hit;
    assign evt_set[gpio_cfg_pkg::EVT_OVERRUN_BIT] = |(edge_hit & flags_reg);
    assign evt_set[gpio_cfg_pkg::EVT_TOGGLE_BIT]  =
        wr_access && paddr == gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_status_reg <= gpio_cfg_pkg::EVENT_RESET;
        else if (wr_access && paddr == gpio_cfg_pkg::EVENT_CLEAR_OFFSET)
            evt_status_reg <= (evt_status_reg & ~pwdata[2:0]) | evt_set;
        else
            evt_status_reg <= evt_status_reg | evt_set;
    end

    // interrupt line lags the flag and enable registers by one edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(flags_reg & ie_reg) | |(evt_status_reg & evt_enable_reg);
    end

    // pad side
    always_comb
    begin
        out_mux = out_reg;
        for (int n = 0; n < 8; n++)
        begin
            unique case ({sel_high_reg[n], sel_low_reg[n]})
                gpio_cfg_pkg::FUNC_GPIO:      out_mux[n] = out_reg[n];
                gpio_cfg_pkg::FUNC_PRIMARY:   out_mux[n] = periph_drive.primary[n];
                gpio_cfg_pkg::FUNC_SECONDARY: out_mux[n] = periph_drive.secondary[n];
                gpio_cfg_pkg::FUNC_TERTIARY:  out_mux[n] = periph_drive.tertiary[n];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_ctrl  <= '0;
            pin_level <= 8'h00;
            func_code <= 16'h0000;
        end
        else
        begin
            pad_ctrl.out_value   <= out_mux;
            pad_ctrl.out_enable  <= dir_reg;
            pad_ctrl.pull_enable <= ren_reg & ~dir_reg;
            pad_ctrl.pull_up     <= out_reg;
            pin_level            <= sync_level;
            for (int n = 0; n < 8; n++)
                func_code[2*n +: 2] <= {sel_high_reg[n], sel_low_reg[n]};
        end
    end

    // APB read mux; write-only locations answer zero
    always_comb
    begin
        rd_value  = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (paddr)
            gpio_cfg_pkg::PIN_DIRECTION_OFFSET:          rd_value[7:0] = dir_reg;
            gpio_cfg_pkg::PULL_RESISTOR_ENABLE_OFFSET:   rd_value[7:0] = ren_reg;
            gpio_cfg_pkg::FUNCTION_SELECT_LOW_OFFSET:    rd_value[7:0] = sel_low_reg;
            gpio_cfg_pkg::FUNCTION_SELECT_HIGH_OFFSET:   rd_value[7:0] = sel_high_reg;
            gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET: rd_value[7:0] = 8'h00;
            gpio_cfg_pkg::IRQ_EDGE_SELECT_OFFSET:        rd_value[7:0] = ies_reg;
            gpio_cfg_pkg::IRQ_ENABLE_OFFSET:             rd_value[7:0] = ie_reg;
            gpio_cfg_pkg::IRQ_FLAGS_OFFSET:              rd_value[7:0] = flags_reg;
            gpio_cfg_pkg::PIN_OUTPUT_VALUE_OFFSET:       rd_value[7:0] = out_reg;
            gpio_cfg_pkg::EVENT_STATUS_OFFSET:           rd_value[2:0] = evt_status_reg;
            gpio_cfg_pkg::EVENT_CLEAR_OFFSET:            rd_value[2:0] = 3'h0;
            gpio_cfg_pkg::EVENT_ENABLE_OFFSET:           rd_value[2:0] = evt_enable_reg;
            default:                                     rd_mapped     = 1'b0;
        endcase
    end

    // answer is prepared in the setup cycle so prdata comes from a flop;
    // this gives a zero-wait access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready  <= 1'b1;
            pslverr <= !rd_mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_value;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    property p_dir_drive;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> pad_ctrl.out_enable == $past(dir_reg);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("oe not from direction");

    property p_pull_enable;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> pad_ctrl.pull_enable == ($past(ren_reg) & ~$past(dir_reg));
    endproperty
    a_pull_enable: assert property (p_pull_enable) else $error("pull enable wrong");

    property p_pull_dir;
        @(posedge pclk) disable iff (!presetn)
        wr_access && paddr == gpio_cfg_pkg::PIN_OUTPUT_VALUE_OFFSET
        |=> ##1 pad_ctrl.pull_up == $past(wdata, 2);
    endproperty
    a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
        wr_access && paddr == gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET
        |=> sel_low_reg == ($past(sel_low_reg) ^ $past(wdata))
            && sel_high_reg == ($past(sel_high_reg) ^ $past(wdata));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle write wrong");

    property p_toggle_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite
        && paddr == gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET |-> prdata == 32'h0000_0000;
    endproperty
    a_toggle_reads_zero: assert property (p_toggle_reads_zero) else $error("toggle read");

    property p_func_code;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> func_code[11:10] == {$past(sel_high_reg[5]), $past(sel_low_reg[5])};
    endproperty
    a_func_code: assert property (p_func_code) else $error("function code order");

    property p_rise_flag;
        @(posedge pclk) disable iff (!presetn)
        |(rise & ~ies_reg) |=> (flags_reg & $past(rise & ~ies_reg)) == $past(rise & ~ies_reg);
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost");

    property p_fall_flag;
        @(posedge pclk) disable iff (!presetn)
        |(fall & ies_reg) |=> (flags_reg & $past(fall & ies_reg)) == $past(fall & ies_reg);
    endproperty
    a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");

    property p_flag_write;
        @(posedge pclk) disable iff (!presetn)
        wr_access && paddr == gpio_cfg_pkg::IRQ_FLAGS_OFFSET && edge_hit == 8'h00
        |=> flags_reg == $past(wdata);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write lost");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        |(flags_reg & ie_reg) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised");

    property p_irq_blocked;
        @(posedge pclk) disable iff (!presetn)
        ie_reg == 8'h00 && (evt_status_reg & evt_enable_reg) == 3'h0 |=> !irq;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked) else $error("irq not masked");

    c_toggle: cover property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET);
    c_rise: cover property (@(posedge pclk) disable iff (!presetn) |(rise & ~ies_reg));
    c_fall: cover property (@(posedge pclk) disable iff (!presetn) |(fall & ies_reg));
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule : gpio_port_config_regs

//--- sim/pin_world_model.sv
`timescale 1ns/1ps
module pin_world_model #(
    parameter logic [7:0] PRIMARY_VALUE   = 8'h5a,
    parameter logic [7:0] SECONDARY_VALUE = 8'h3c,
    parameter logic [7:0] TERTIARY_VALUE  = 8'h96
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire gpio_cfg_pkg::pad_ctrl_type     pad_ctrl,
    input  wire logic [7:0]                     ext_enable,
    input  wire logic [7:0]                     ext_level,
    output logic      [7:0]                     pin_in,
    output gpio_cfg_pkg::periph_drive_type      periph_drive
);
    logic [7:0] float_reg;

    // a pad nobody drives or pulls wanders, so it flips every cycle instead of holding
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            float_reg <= 8'h55;
        else
            float_reg <= ~float_reg;
    end

    assign periph_drive = {TERTIARY_VALUE, SECONDARY_VALUE, PRIMARY_VALUE};

    // the port's own driver wins over the outside world on the same pin
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pad_ctrl.out_enable[i])
                pin_in[i] = pad_ctrl.out_value[i];
            else if (ext_enable[i])
                pin_in[i] = ext_level[i];
            else if (pad_ctrl.pull_enable[i])
                pin_in[i] = pad_ctrl.pull_up[i];
            else
                pin_in[i] = float_reg[i];
        end
    end
endmodule : pin_world_model

//--- sim/gpio_port_config_regs_test.sv
`timescale 1ns/1ps
module gpio_port_config_regs_test;
    localparam logic [7:0] PRI = 8'h5a;
    localparam logic [7:0] SEC = 8'h3c;
    localparam logic [7:0] TER = 8'h96;
    logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic                           rerr;
    logic [11:0]                    paddr;
    logic [31:0]                    pwdata, prdata, rdat;
    logic [7:0]                     pin_in, pin_level, ext_enable, ext_level;
    logic [15:0]                    func_code;
    gpio_cfg_pkg::pad_ctrl_type     pad_ctrl;
    gpio_cfg_pkg::periph_drive_type periph_drive;
    int                             fails, n_tests;

    gpio_port_config_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .periph_drive(periph_drive), .pad_ctrl(pad_ctrl),
        .pin_level(pin_level), .func_code(func_code), .irq(irq));

    pin_world_model #(.PRIMARY_VALUE(PRI), .SECONDARY_VALUE(SEC), .TERTIARY_VALUE(TER)) world (
        .pclk(pclk), .presetn(presetn), .pad_ctrl(pad_ctrl), .ext_enable(ext_enable),
        .ext_level(ext_level), .pin_in(pin_in), .periph_drive(periph_drive));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task report_and_stop;
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // one APB transfer; the request stands until pready is seen high at an edge
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        check("pready", 32'h1, {31'h0, pready});
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [7:0] d, input logic e = 1'b0);
        xfer(a, 1'b1, {24'h0, d});
        check($sformatf("write error %h", a), {31'h0, e}, {31'h0, rerr});
    endtask : wr

    task rd(input logic [11:0] a, input logic [7:0] exp, input logic e = 1'b0);
        xfer(a, 1'b0, 32'h0);
        check($sformatf("read %h", a), {24'h0, exp}, rdat);
        check($sformatf("read error %h", a), {31'h0, e}, {31'h0, rerr});
    endtask : rd

    // covers the 2-flop pin sync, the flag edge and the registered irq
    task settle;
        repeat (6) @(posedge pclk);
    endtask : settle

    function automatic logic [15:0] exp_code(input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] r;
        for (int i = 0; i < 8; i++)
            r[2*i +: 2] = {hi[i], lo[i]};
        return r;
    endfunction : exp_code

    function automatic logic [7:0] exp_out(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] ov);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = hi[i] ? (lo[i] ? TER[i] : SEC[i]) : (lo[i] ? PRI[i] : ov[i]);
        return r;
    endfunction : exp_out

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        report_and_stop();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        fails = 0;
        n_tests = 0;
        presetn = 1'b0;
        ext_enable = 8'hff;
        ext_level = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++)
            rd(12'(i * 4), 8'h00);
        rd(12'h030, 8'h00, 1'b1);
        wr(12'h030, 8'hff, 1'b1);
        // pad control: outputs on the low nibble, pulls on the high nibble
        wr(gpio_cfg_pkg::PIN_OUTPUT_VALUE_OFFSET, 8'h35);
        wr(gpio_cfg_pkg::PIN_DIRECTION_OFFSET, 8'h0f);
        wr(gpio_cfg_pkg::PULL_RESISTOR_ENABLE_OFFSET, 8'hff);
        ext_enable <= 8'h00;
        settle();
        check("out_enable", 8'h0f, pad_ctrl.out_enable);
        check("pull_enable", 8'hf0, pad_ctrl.pull_enable);
        check("pull_up", 8'h35, pad_ctrl.pull_up);
        check("pin_level", 8'h35, pin_level);
        rd(gpio_cfg_pkg::PIN_DIRECTION_OFFSET, 8'h0f);
        ext_enable <= 8'hff;
        // every function code, then an atomic complement of pins 0 to 3
        wr(gpio_cfg_pkg::FUNCTION_SELECT_LOW_OFFSET, 8'hcc);
        wr(gpio_cfg_pkg::FUNCTION_SELECT_HIGH_OFFSET, 8'hf0);
        settle();
        check("func_code", exp_code(8'hcc, 8'hf0), func_code);
        check("out_value", exp_out(8'hcc, 8'hf0, 8'h35), pad_ctrl.out_value);
        wr(gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET, 8'h0f);
        rd(gpio_cfg_pkg::FUNCTION_SELECT_LOW_OFFSET, 8'hc3);
        rd(gpio_cfg_pkg::FUNCTION_SELECT_HIGH_OFFSET, 8'hff);
        rd(gpio_cfg_pkg::FUNCTION_SELECT_TOGGLE_OFFSET, 8'h00);
        settle();
        check("func_code", exp_code(8'hc3, 8'hff), func_code);
        check("out_value", exp_out(8'hc3, 8'hff, 8'h35), pad_ctrl.out_value);
        // pin interrupts: falling on the low nibble, only pin 0 enabled
        wr(gpio_cfg_pkg::PIN_DIRECTION_OFFSET, 8'h00);
        wr(gpio_cfg_pkg::IRQ_EDGE_SELECT_OFFSET, 8'h0f);
        wr(gpio_cfg_pkg::IRQ_ENABLE_OFFSET, 8'h01);
        settle();
        wr(gpio_cfg_pkg::IRQ_FLAGS_OFFSET, 8'h00);
        wr(gpio_cfg_pkg::EVENT_CLEAR_OFFSET, 8'h07);
        rd(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h00);
        ext_level <= 8'hff;
        settle();
        rd(gpio_cfg_pkg::IRQ_FLAGS_OFFSET, 8'hf0);
        check("irq masked", 32'h0, {31'h0, irq});
        rd(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h01);
        ext_level <= 8'h00;
        settle();
        rd(gpio_cfg_pkg::IRQ_FLAGS_OFFSET, 8'hff);
        check("irq pending", 32'h1, {31'h0, irq});
        ext_level <= 8'hff;
        settle();
        rd(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h03);
        wr(gpio_cfg_pkg::IRQ_FLAGS_OFFSET, 8'h00);
        settle();
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(gpio_cfg_pkg::IRQ_FLAGS_OFFSET, 8'h01);
        settle();
        check("irq soft set", 32'h1, {31'h0, irq});
        wr(gpio_cfg_pkg::IRQ_ENABLE_OFFSET, 8'h00);
        settle();
        check("irq disabled", 32'h0, {31'h0, irq});
        // event interrupt: enable, read-only status, write-one clear
        wr(gpio_cfg_pkg::EVENT_ENABLE_OFFSET, 8'h02);
        settle();
        check("irq event", 32'h1, {31'h0, irq});
        wr(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h00);
        rd(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h03);
        wr(gpio_cfg_pkg::EVENT_CLEAR_OFFSET, 8'h02);
        settle();
        check("irq event cleared", 32'h0, {31'h0, irq});
        rd(gpio_cfg_pkg::EVENT_STATUS_OFFSET, 8'h01);
        rd(gpio_cfg_pkg::EVENT_CLEAR_OFFSET, 8'h00);
        report_and_stop();
    end
endmodule : gpio_port_config_regs_test
